// ### pkg/mss_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts of the stage sequencer.
// Assumes: 32-bit APB, one aligned word per register, 250 MHz pclk.
// Notes:   Stage times are held in tenths of the selected unit.
`ifndef MSS_CFG_SVH
`define MSS_CFG_SVH

`define MSS_OFF_MODE    12'h000
`define MSS_OFF_STATUS  12'h004
`define MSS_OFF_IRQ_ST  12'h008
`define MSS_OFF_IRQ_MSK 12'h00C
`define MSS_OFF_FMAX    12'h010
`define MSS_OFF_CAPT    12'h014
`define MSS_OFF_OUTSEL  12'h018
`define MSS_SEG_RAMP    8'h02
`define MSS_SEG_FREF    6'h01
`define MSS_SEG_TIME    6'h02

`define MSS_F_CYC   0
`define MSS_F_START 4
`define MSS_F_RET   8
`define MSS_F_UNIT  12

`define MSS_CYC_MAX   4'h2
`define MSS_FLAG_MAX  4'h1
`define MSS_RAMP_MAX  4'h3
`define MSS_FREF_FULL 16'h03E8

`define MSS_RST_MODE  16'h0000
`define MSS_RST_RAMP  16'h0000
`define MSS_RST_FREF  16'h0000
`define MSS_RST_TIME  16'h0000
`define MSS_RST_FMAX  16'h1388

`define MSS_CLK_NS      32'h00000004
`define MSS_TENTH_NS    32'h05F5E100
`define MSS_TENTH_MS    32'h00000064
`define MSS_PULSE_MS    32'h000001F4
`define MSS_MIN_TENTHS  6'h3C

`endif

// ### pkg/mss_pkg.sv
// Purpose: Types shared by the stage sequencer.
// Assumes: Nothing beyond the cfg header.
// Notes:   Idle is the first state; reset also loads st_idle by name.
package mss_pkg;
  typedef enum logic [1:0] {st_idle, st_run, st_hold, st_done} mss_state_t;
endpackage

// ### rtl/mss_tick_gen.sv
// Purpose: Free-running divider giving a one-cycle enable every DIV clocks.
// Assumes: Single pclk domain.
// Notes:   Used as the 0.1 s time base of the sequencer.
module mss_tick_gen #(
  parameter int unsigned DIV = 25000000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } mss_tick_st_t;

  mss_tick_st_t cur_r;
  mss_tick_st_t cur_nxt;

  if (DIV < 2) begin : g_bad_div
    $error("DIV must be at least 2");
  end

  always_comb
  begin
    cur_nxt = cur_r;
    cur_nxt.tick = 1'b0;
    if (cur_r.cnt == 32'(DIV - 1))
    begin
      cur_nxt.cnt = 32'h00000000;
      cur_nxt.tick = 1'b1;
    end
    else
      cur_nxt.cnt = cur_r.cnt + 32'h00000001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_r <= '0;
    else
      cur_r <= cur_nxt;
  end

  assign tick = cur_r.tick;
endmodule // mss_tick_gen

// ### rtl/mss_sequencer.sv
// Purpose: Multi-stage speed sequencer with APB registers and pulse indications.
// Assumes: Run, direction, fault, power-fail, pause and clear arrive asynchronously on pins.
// Notes:   Stage timing has 0.1 s granularity in seconds mode and 6 s in minutes mode, against a free-running time base.
`include "mss_cfg.svh"
module mss_sequencer #(
  parameter int unsigned TENTH_CYC = `MSS_TENTH_NS / `MSS_CLK_NS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        run_cmd_pin,
  input  wire logic        dir_cmd_pin,
  input  wire logic        fault_pin,
  input  wire logic        power_fail_pin,
  input  wire logic        seq_pause_di,
  input  wire logic        mem_clear_di,
  output logic             drive_run,
  output logic             drive_dir_rev,
  output logic      [31:0] freq_ref_out,
  output logic      [1:0]  ramp_sel,
  output logic      [3:0]  stage_idx,
  output logic             open_collector_output_a,
  output logic             open_collector_output_b,
  output logic             relay_output,
  output logic             irq
);
  localparam logic [2:0] PULSE_TICKS = 3'(`MSS_PULSE_MS / `MSS_TENTH_MS);
  localparam int         I_RUN = 0;
  localparam int         I_DIR = 1;
  localparam int         I_FLT = 2;
  localparam int         I_PF  = 3;
  localparam int         I_PAU = 4;
  localparam int         I_CLR = 5;

  typedef struct packed {
    logic [5:0]        s1;
    logic [5:0]        s2;
    logic [5:0]        prev;
    logic [15:0]       mode;
    logic [3:0][15:0]  ramp;
    logic [15:0][15:0] fref;
    logic [15:0][15:0] ftime;
    logic [15:0]       fmax;
    logic              outsel;
    logic [1:0]        irq_st;
    logic [1:0]        irq_mask;
    logic [31:0]       prdata;
    mss_pkg::mss_state_t fsm;
    logic [3:0]        stage;
    logic [15:0]       elapsed;
    logic [5:0]        unit_cnt;
    logic              resume;
    logic              dir_rev;
    logic              dir_out;
    logic [2:0]        sdone;
    logic [2:0]        cdone;
    logic [31:0]       freq;
    logic [1:0]        ramp_o;
    logic [15:0]       cap_time;
    logic [15:0]       cap_freq;
  } mss_core_t;

  mss_core_t cur_r;
  mss_core_t cur_nxt;

  logic        tick;
  logic        run_rise, run_fall, fault_rise, pf_rise, pause, clr;
  logic        unit_tick, stage_end, cyc_ev, stop_any, running;
  logic [5:0]  nx, first;
  logic [3:0]  cmode, smode, rmode, umode;
  logic        setup, access, hit_any, wr_bad;
  logic        hit_mode, hit_stat, hit_ist, hit_msk, hit_fmax, hit_capt, hit_osel;
  logic        hit_ramp, hit_fref, hit_time;
  logic [31:0] rd_val;
  logic [10:0] mag;
  logic [31:0] scaled;

  mss_tick_gen #(
    .DIV (TENTH_CYC)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  // Nearest enabled stage after cur_i; bit 5 found, bit 4 wrapped past the last stage.
  function automatic logic [5:0] mss_next(input logic [3:0] cur_i,
                                          input logic [15:0][15:0] t);
    logic [5:0] r;
    logic [4:0] j;
    r = 6'h00;
    for (int i = 16; i >= 1; i--)
    begin
      j = 5'(cur_i) + 5'(i);
      if (t[j[3:0]] != `MSS_RST_TIME)
        r = {1'b1, j[4], j[3:0]};
    end
    return r;
  endfunction

  assign cmode      = cur_r.mode[`MSS_F_CYC +: 4];
  assign smode      = cur_r.mode[`MSS_F_START +: 4];
  assign rmode      = cur_r.mode[`MSS_F_RET +: 4];
  assign umode      = cur_r.mode[`MSS_F_UNIT +: 4];
  assign run_rise   = cur_r.s2[I_RUN] & ~cur_r.prev[I_RUN];
  assign run_fall   = ~cur_r.s2[I_RUN] & cur_r.prev[I_RUN];
  assign fault_rise = cur_r.s2[I_FLT] & ~cur_r.prev[I_FLT];
  assign pf_rise    = cur_r.s2[I_PF] & ~cur_r.prev[I_PF];
  assign pause      = cur_r.s2[I_PAU];
  assign clr        = cur_r.s2[I_CLR];
  assign running    = (cur_r.fsm == mss_pkg::st_run) || (cur_r.fsm == mss_pkg::st_hold);
  assign stop_any   = pf_rise || ((cur_r.fsm != mss_pkg::st_idle) && (run_fall || fault_rise));
  assign nx         = mss_next(cur_r.stage, cur_r.ftime);
  assign first      = mss_next(4'hF, cur_r.ftime);
  // Minutes advance the stage clock once per 60 tenth-second ticks.
  assign unit_tick  = tick && ((umode == 4'h0) || (cur_r.unit_cnt == `MSS_MIN_TENTHS - 6'h01));
  assign stage_end  = (cur_r.fsm == mss_pkg::st_run) && unit_tick && !pause &&
                      (({1'b0, cur_r.elapsed} + 17'h00001) >= {1'b0, cur_r.ftime[cur_r.stage]});
  assign cyc_ev     = stage_end && (nx[4] || !nx[5]);

  assign mag    = cur_r.fref[cur_r.stage][15] ? 11'(-cur_r.fref[cur_r.stage]) :
                                                 11'(cur_r.fref[cur_r.stage]);
  assign scaled = ({21'h000000, mag} * {16'h0000, cur_r.fmax}) / {16'h0000, `MSS_FREF_FULL};

  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign hit_mode = paddr == `MSS_OFF_MODE;
  assign hit_stat = paddr == `MSS_OFF_STATUS;
  assign hit_ist  = paddr == `MSS_OFF_IRQ_ST;
  assign hit_msk  = paddr == `MSS_OFF_IRQ_MSK;
  assign hit_fmax = paddr == `MSS_OFF_FMAX;
  assign hit_capt = paddr == `MSS_OFF_CAPT;
  assign hit_osel = paddr == `MSS_OFF_OUTSEL;
  assign hit_ramp = (paddr[11:4] == `MSS_SEG_RAMP) && (paddr[1:0] == 2'h0);
  assign hit_fref = (paddr[11:6] == `MSS_SEG_FREF) && (paddr[1:0] == 2'h0);
  assign hit_time = (paddr[11:6] == `MSS_SEG_TIME) && (paddr[1:0] == 2'h0);
  assign hit_any  = hit_mode | hit_stat | hit_ist | hit_msk | hit_fmax | hit_capt |
                    hit_osel | hit_ramp | hit_fref | hit_time;

  // Out-of-range writes are refused whole rather than clipped, so software sees the error.
  always_comb
  begin
    wr_bad = 1'b0;
    if (hit_mode)
      wr_bad = (pwdata[`MSS_F_CYC +: 4] > `MSS_CYC_MAX) ||
               (pwdata[`MSS_F_START +: 4] > `MSS_FLAG_MAX) ||
               (pwdata[`MSS_F_RET +: 4] > `MSS_FLAG_MAX) ||
               (pwdata[`MSS_F_UNIT +: 4] > `MSS_FLAG_MAX);
    else if (hit_ramp)
      wr_bad = (pwdata[1:0] != pwdata[1:0]) || (pwdata[3:0] > `MSS_RAMP_MAX) ||
               (pwdata[7:4] > `MSS_RAMP_MAX) || (pwdata[11:8] > `MSS_RAMP_MAX) ||
               (pwdata[15:12] > `MSS_RAMP_MAX);
    else if (hit_fref)
      wr_bad = ($signed(pwdata[15:0]) > $signed(`MSS_FREF_FULL)) ||
               ($signed(pwdata[15:0]) < -$signed(`MSS_FREF_FULL));
  end

  always_comb
  begin
    rd_val = 32'h00000000;
    if (hit_mode)
      rd_val = {16'h0000, cur_r.mode};
    else if (hit_stat)
      rd_val = {24'h000000, cur_r.dir_rev, cur_r.resume, cur_r.fsm, cur_r.stage};
    else if (hit_ist)
      rd_val = {30'h00000000, cur_r.irq_st};
    else if (hit_msk)
      rd_val = {30'h00000000, cur_r.irq_mask};
    else if (hit_fmax)
      rd_val = {16'h0000, cur_r.fmax};
    else if (hit_capt)
      rd_val = {cur_r.cap_freq, cur_r.cap_time};
    else if (hit_osel)
      rd_val = {31'h00000000, cur_r.outsel};
    else if (hit_ramp)
      rd_val = {16'h0000, cur_r.ramp[paddr[3:2]]};
    else if (hit_fref)
      rd_val = {{16{cur_r.fref[paddr[5:2]][15]}}, cur_r.fref[paddr[5:2]]};
    else if (hit_time)
      rd_val = {16'h0000, cur_r.ftime[paddr[5:2]]};
  end

  always_comb
  begin
    cur_nxt = cur_r;
    cur_nxt.s1   = {mem_clear_di, seq_pause_di, power_fail_pin, fault_pin, dir_cmd_pin,
                    run_cmd_pin};
    cur_nxt.s2   = cur_r.s1;
    cur_nxt.prev = cur_r.s2;
    if (setup)
      cur_nxt.prdata = rd_val;
    if (access && pwrite && hit_any && !wr_bad)
    begin
      if (hit_mode)
        cur_nxt.mode = pwdata[15:0];
      if (hit_msk)
        cur_nxt.irq_mask = pwdata[1:0];
      if (hit_fmax)
        cur_nxt.fmax = pwdata[15:0];
      if (hit_osel)
        cur_nxt.outsel = pwdata[0];
      if (hit_ramp)
        cur_nxt.ramp[paddr[3:2]] = pwdata[15:0];
      if (hit_fref)
        cur_nxt.fref[paddr[5:2]] = pwdata[15:0];
      if (hit_time)
        cur_nxt.ftime[paddr[5:2]] = pwdata[15:0];
    end
    // A completion in the same cycle as its write-one clear stays set.
    cur_nxt.irq_st = (cur_r.irq_st & ~((access && pwrite && hit_ist) ? pwdata[1:0] : 2'h0)) |
                     {cyc_ev, stage_end};

    if (tick && (cur_r.sdone != 3'h0))
      cur_nxt.sdone = cur_r.sdone - 3'h1;
    if (tick && (cur_r.cdone != 3'h0))
      cur_nxt.cdone = cur_r.cdone - 3'h1;

    case (cur_r.fsm)
      mss_pkg::st_idle:
      begin
        if (run_rise && first[5])
        begin
          cur_nxt.fsm = mss_pkg::st_run;
          if (!(cur_r.resume && (cur_r.ftime[cur_r.stage] != `MSS_RST_TIME)))
          begin
            cur_nxt.stage    = first[3:0];
            cur_nxt.elapsed  = 16'h0000;
            cur_nxt.unit_cnt = 6'h00;
          end
        end
      end
      mss_pkg::st_run:
      begin
        if (tick && !pause)
          cur_nxt.unit_cnt = (cur_r.unit_cnt == `MSS_MIN_TENTHS - 6'h01) ? 6'h00 :
                             cur_r.unit_cnt + 6'h01;
        if (stage_end)
        begin
          cur_nxt.sdone   = PULSE_TICKS;
          cur_nxt.elapsed = 16'h0000;
          if (!cyc_ev)
            cur_nxt.stage = nx[3:0];
          else
          begin
            cur_nxt.cdone = PULSE_TICKS;
            if (cmode == 4'h0)
            begin
              cur_nxt.fsm    = mss_pkg::st_done;
              cur_nxt.resume = 1'b0;
            end
            else if (cmode == 4'h1)
            begin
              cur_nxt.fsm     = mss_pkg::st_hold;
              cur_nxt.elapsed = cur_r.elapsed;
            end
            else if (first[5])
              cur_nxt.stage = first[3:0];
            else
              cur_nxt.fsm = mss_pkg::st_idle;
          end
        end
        else if (unit_tick && !pause)
          cur_nxt.elapsed = cur_r.elapsed + 16'h0001;
      end
      mss_pkg::st_hold:
        cur_nxt.fsm = mss_pkg::st_hold;
      mss_pkg::st_done:
        cur_nxt.fsm = mss_pkg::st_done;
      default:
        cur_nxt.fsm = mss_pkg::st_idle;
    endcase

    if (stop_any)
    begin
      cur_nxt.fsm      = mss_pkg::st_idle;
      cur_nxt.stage    = cur_r.stage;
      cur_nxt.elapsed  = cur_r.elapsed;
      cur_nxt.sdone    = cur_r.sdone;
      cur_nxt.cdone    = cur_r.cdone;
      cur_nxt.cap_time = cur_r.elapsed;
      cur_nxt.cap_freq = cur_r.freq[15:0];
      cur_nxt.resume   = (smode == 4'h1) && (!pf_rise || (rmode == 4'h1));
      if (pf_rise && (rmode == 4'h0))
      begin
        cur_nxt.stage   = 4'h0;
        cur_nxt.elapsed = 16'h0000;
      end
    end
    if (clr)
      cur_nxt.resume = 1'b0;

    if (cur_r.fref[cur_r.stage] != `MSS_RST_FREF)
      cur_nxt.dir_rev = cur_r.fref[cur_r.stage][15];
    cur_nxt.dir_out = cur_r.dir_rev ^ cur_r.s2[I_DIR];
    cur_nxt.freq    = running ? scaled : 32'h00000000;
    cur_nxt.ramp_o  = cur_r.ramp[cur_r.stage[3:2]][{cur_r.stage[1:0], 2'h0} +: 2];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_r      <= '0;
      cur_r.fmax <= `MSS_RST_FMAX;
      cur_r.fsm  <= mss_pkg::st_idle;
    end
    else
      cur_r <= cur_nxt;
  end

  assign prdata                  = cur_r.prdata;
  assign pready                  = access;
  assign pslverr                 = access && (!hit_any || (pwrite && wr_bad));
  assign drive_run               = running;
  assign drive_dir_rev           = cur_r.dir_out;
  assign freq_ref_out            = cur_r.freq;
  assign ramp_sel                = cur_r.ramp_o;
  assign stage_idx               = cur_r.stage;
  assign open_collector_output_a = cur_r.sdone != 3'h0;
  assign open_collector_output_b = cur_r.cdone != 3'h0;
  assign relay_output            = cur_r.outsel ? (cur_r.cdone != 3'h0) : (cur_r.sdone != 3'h0);
  assign irq                     = |(cur_r.irq_st & cur_r.irq_mask);

  logic [2:0] ticks_hi;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ticks_hi <= 3'h0;
    else if (stage_end)
      ticks_hi <= 3'h0;
    else if (tick && (cur_r.sdone != 3'h0))
      ticks_hi <= ticks_hi + 3'h1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cycle_end(logic [3:0] m);
    cyc_ev && !stop_any && (cmode == m);
  endsequence
  sequence s_fresh_start;
    (cur_r.fsm == mss_pkg::st_idle) && run_rise && first[5] && !cur_r.resume && !pf_rise;
  endsequence

  property p_mode_range;
    (cmode <= `MSS_CYC_MAX) && (smode <= `MSS_FLAG_MAX) && (rmode <= `MSS_FLAG_MAX) &&
    (umode <= `MSS_FLAG_MAX);
  endproperty
  a_mode_range: assert property (p_mode_range) else $error("mode field out of range");

  property p_stop_cycle;
    s_cycle_end(4'h0) |=> (cur_r.fsm == mss_pkg::st_done) && !drive_run ##1 !drive_run;
  endproperty
  a_stop_cycle: assert property (p_stop_cycle) else $error("mode 0 did not stop");

  property p_hold_cycle;
    s_cycle_end(4'h1) |=> (cur_r.fsm == mss_pkg::st_hold) && $stable(cur_r.stage) && drive_run;
  endproperty
  a_hold_cycle: assert property (p_hold_cycle) else $error("mode 1 did not hold");

  property p_repeat_cycle;
    s_cycle_end(4'h2) |=> (cur_r.fsm == mss_pkg::st_run) && (cur_r.elapsed == 16'h0000) &&
                          (cur_r.stage == $past(first[3:0]));
  endproperty
  a_repeat_cycle: assert property (p_repeat_cycle) else $error("mode 2 did not repeat");

  property p_fresh_start;
    s_fresh_start |=> (cur_r.stage == $past(first[3:0])) && (cur_r.elapsed == 16'h0000);
  endproperty
  a_fresh_start: assert property (p_fresh_start) else $error("start not at first stage");

  property p_capture;
    stop_any && !pf_rise && (smode == 4'h1) && !clr |=>
      cur_r.resume && (cur_r.cap_time == $past(cur_r.elapsed)) && $stable(cur_r.stage);
  endproperty
  a_capture: assert property (p_capture) else $error("stop state not captured");

  property p_pf_discard;
    pf_rise && (rmode == 4'h0) |=> (cur_r.stage == 4'h0) && (cur_r.elapsed == 16'h0000) &&
                                   !cur_r.resume && !drive_run;
  endproperty
  a_pf_discard: assert property (p_pf_discard) else $error("power loss kept state");

  property p_pf_keep;
    pf_rise && (rmode == 4'h1) |=> $stable(cur_r.stage) && $stable(cur_r.elapsed);
  endproperty
  a_pf_keep: assert property (p_pf_keep) else $error("power loss lost state");

  property p_skip_zero;
    (cur_r.fsm != mss_pkg::st_run) ##1 (cur_r.fsm == mss_pkg::st_run) |->
      ($past(cur_r.ftime[cur_r.stage]) != `MSS_RST_TIME);
  endproperty
  a_skip_zero: assert property (p_skip_zero) else $error("zero-time stage entered");

  property p_pulse_len;
    $fell(open_collector_output_a) |-> (ticks_hi == PULSE_TICKS);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("stage pulse length wrong");

  property p_pause;
    (cur_r.fsm == mss_pkg::st_run) && pause && !stop_any |=> $stable(cur_r.elapsed);
  endproperty
  a_pause: assert property (p_pause) else $error("elapsed moved while paused");

  property p_dir;
    (cur_r.fref[cur_r.stage] == `MSS_RST_FREF) |=> $stable(cur_r.dir_rev) ##1
      (drive_dir_rev == ($past(cur_r.dir_rev) ^ $past(cur_r.s2[I_DIR])));
  endproperty
  a_dir: assert property (p_dir) else $error("direction not kept");

  property p_advance;
    stage_end && !cyc_ev && !stop_any |=> (cur_r.stage == $past(nx[3:0])) &&
                                          (cur_r.elapsed == 16'h0000);
  endproperty
  a_advance: assert property (p_advance) else $error("stage did not advance");
endmodule // mss_sequencer

// ### verification/mss_term_model.sv
// Purpose: Terminal-side model that drives the command and terminal pins of the sequencer.
// Assumes: The bench raises requests by index; each pin follows on the next pclk edge.
// Notes:   Index 0 run, 1 dir, 2 fault, 3 power loss, 4 pause, 5 memory clear.
module mss_term_model (
  input  wire logic       pclk,
  input  wire logic [5:0] req,
  output logic            run_cmd_pin,
  output logic            dir_cmd_pin,
  output logic            fault_pin,
  output logic            power_fail_pin,
  output logic            seq_pause_di,
  output logic            mem_clear_di
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] pin_r = 6'h00;
  always @(posedge pclk)
  begin
    pin_r <= req;
  end
  assign {mem_clear_di, seq_pause_di, power_fail_pin} = pin_r[5:3];
  assign {fault_pin, dir_cmd_pin, run_cmd_pin} = pin_r[2:0];
endmodule  // mss_term_model

// ### verification/multi_speed_stage_sequencer_bench.sv
// Purpose: Self-checking bench for the stage sequencer over APB and terminal pins.
// Assumes: Time base shortened to ten cycles per tenth of a second.
// Notes:   Maximum frequency is set to 1000 so the output equals the reference.
module multi_speed_stage_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TC = 10;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, freq_ref_out, rd;
  logic [5:0]  req = 6'h00;
  logic [3:0]  stage_idx, ps [3];
  logic [15:0] pm [3];
  logic [1:0]  ramp_sel;
  logic        pready, pslverr, er, drive_run, drive_dir_rev, oca, ocb, irq;
  logic        run_p, dir_p, flt_p, pf_p, pau_p, clr_p;
  int          mismatches = 0, checked = 0, n;
  mss_sequencer #(.TENTH_CYC(TC)) u_mss_sequencer (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .run_cmd_pin(run_p),
    .dir_cmd_pin(dir_p), .fault_pin(flt_p), .power_fail_pin(pf_p), .seq_pause_di(pau_p),
    .mem_clear_di(clr_p), .drive_run(drive_run), .drive_dir_rev(drive_dir_rev),
    .freq_ref_out(freq_ref_out), .ramp_sel(ramp_sel), .stage_idx(stage_idx),
    .open_collector_output_a(oca), .open_collector_output_b(ocb), .relay_output(), .irq(irq));
  mss_term_model u_mss_term_model (.pclk(pclk), .req(req), .run_cmd_pin(run_p),
    .dir_cmd_pin(dir_p), .fault_pin(flt_p), .power_fail_pin(pf_p), .seq_pause_di(pau_p),
    .mem_clear_di(clr_p));
  initial
  begin
    forever #2 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  // The request is held until pready is sampled high, so slow answers are tolerated.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrc(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk(er, e);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask
  task automatic pin(input int i, input logic v);
    @(posedge pclk);
    req[i] <= v;
  endtask
  task automatic wait_stage(input logic [3:0] s);
    while (stage_idx !== s) @(posedge pclk);
  endtask
  task automatic wait_run(input logic v);
    while (drive_run !== v) @(posedge pclk);
  endtask
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge pclk);
    mismatches++;
    report_and_stop();
  end
  initial
  begin
    pm = '{16'h0010, 16'h0110, 16'h0100};
    ps = '{4'h0, 4'h2, 4'h0};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h000, 32'h0);
    rdc(12'h080, 32'h0);
    rdc(12'h020, 32'h0);
    wrc(12'h000, 32'h3, 1'b1);
    wrc(12'h020, 32'h4, 1'b1);
    wrc(12'h040, 32'h3E9, 1'b1);
    wrc(12'h000, 32'h1112, 1'b0);
    wrc(12'h01C, 32'h0, 1'b1);
    wrc(12'h010, 32'h3E8, 1'b0);
    wrc(12'h040, 32'h1F4, 1'b0);
    wrc(12'h048, 32'hFFFFFF06, 1'b0);
    rdc(12'h048, 32'hFFFFFF06);
    wrc(12'h080, 32'h2, 1'b0);
    wrc(12'h088, 32'h1, 1'b0);
    wrc(12'h020, 32'h0302, 1'b0);
    wrc(12'h000, 32'h0, 1'b0);
    pin(0, 1'b1);
    wait_run(1'b1);
    repeat (2) @(posedge pclk);
    chk(freq_ref_out, 32'h1F4);
    chk(ramp_sel, 2'h2);
    wait_stage(4'h2);
    repeat (2) @(posedge pclk);
    chk(freq_ref_out, 32'hFA);
    chk({drive_dir_rev, ramp_sel}, 3'h7);
    while (ocb !== 1'b1) @(posedge pclk);
    n = 0;
    while (ocb === 1'b1)
    begin
      @(posedge pclk);
      n++;
    end
    chk(n, 5 * TC);
    chk({drive_run, irq}, 2'h0);
    wrc(12'h00C, 32'h3, 1'b0);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    wrc(12'h008, 32'h3, 1'b0);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    pin(0, 1'b0);
    wrc(12'h000, 32'h1, 1'b0);
    pin(0, 1'b1);
    wait_stage(4'h2);
    pin(1, 1'b1);
    repeat (100) @(posedge pclk);
    chk({drive_run, stage_idx, freq_ref_out}, {5'h12, 32'hFA});
    chk(drive_dir_rev, 1'b0);
    pin(1, 1'b0);
    pin(0, 1'b0);
    wait_run(1'b0);
    wrc(12'h000, 32'h2, 1'b0);
    pin(0, 1'b1);
    wait_stage(4'h2);
    wait_stage(4'h0);
    chk(drive_run, 1'b1);
    pin(0, 1'b0);
    wait_run(1'b0);
    wrc(12'h088, 32'h28, 1'b0);
    wrc(12'h000, 32'h10, 1'b0);
    pin(0, 1'b1);
    wait_stage(4'h2);
    pin(4, 1'b1);
    repeat (600) @(posedge pclk);
    chk(stage_idx, 4'h2);
    pin(4, 1'b0);
    pin(0, 1'b0);
    wait_run(1'b0);
    pin(0, 1'b1);
    wait_run(1'b1);
    repeat (2) @(posedge pclk);
    chk(stage_idx, 4'h2);
    pin(0, 1'b0);
    wait_run(1'b0);
    pin(5, 1'b1);
    repeat (5) @(posedge pclk);
    pin(5, 1'b0);
    pin(0, 1'b1);
    wait_run(1'b1);
    repeat (2) @(posedge pclk);
    chk(stage_idx, 4'h0);
    pin(0, 1'b0);
    wait_run(1'b0);
    for (int i = 0; i < 3; i++)
    begin
      wrc(12'h000, {16'h0, pm[i]}, 1'b0);
      pin(0, 1'b1);
      wait_stage(4'h2);
      pin(3, 1'b1);
      wait_run(1'b0);
      pin(3, 1'b0);
      pin(0, 1'b0);
      repeat (5) @(posedge pclk);
      pin(0, 1'b1);
      wait_run(1'b1);
      repeat (2) @(posedge pclk);
      chk(stage_idx, ps[i]);
      pin(0, 1'b0);
      wait_run(1'b0);
    end
    wrc(12'h000, 32'h1000, 1'b0);
    pin(0, 1'b1);
    repeat (100) @(posedge pclk);
    chk({drive_run, stage_idx}, 5'h10);
    report_and_stop();
  end
endmodule  // multi_speed_stage_sequencer_bench
